// ==== adc_seq_regs.svh ====
// Purpose: Offsets, field positions and reset values of the sequencer registers
// Assumes: 32-bit Wishbone data, byte addresses, one register per aligned word
// Notes:   Definitions only
`ifndef ADC_SEQ_REGS_SVH
`define ADC_SEQ_REGS_SVH

`define CTRL_OFS        8'h00
`define STAT_OFS        8'h04
`define IRQ_STAT_OFS    8'h08
`define IRQ_MASK_OFS    8'h0C
`define RIGHT_VIEW_OFS  8'h40
`define LSIGN_VIEW_OFS  8'h60
`define LUNS_VIEW_OFS   8'h80

`define CTRL_SCAN_BIT   6
`define CTRL_MULTICHANNEL_SELECT_BIT   5
`define CTRL_EIGHT_BIT  4
`define CTRL_RESET      7'h00
`define STAT_SEQ_BIT    15
`define IRQ_SLOT_BIT    0
`define IRQ_SEQ_BIT     1

`endif

// ==== adc_seq_pkg.sv ====
// Purpose: Types shared by the channel sequencer
// Assumes: Nothing beyond the register header
// Notes:   Binary state codes are written out
package adc_seq_pkg;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_START = 2'b01,
    ST_WAIT  = 2'b10
  } seq_state_e;
  typedef logic [3:0] chan_t;
  typedef logic [2:0] slot_t;
endpackage

// ==== adc_channel_sequence_select.sv ====
// Purpose: Channel and result-slot sequencing of an A/D converter controller
// Assumes: Converter core on I_CLK; it answers each start with one done pulse
// Notes:   Wishbone classic slave, registered ack one cycle after request
//
// What this block does
// - Channel codes 0-7 pick analog inputs, 8-11 reserved, 12 high ref, 13 low, 14 mid, 15 test.
// - Without multichannel one channel is converted repeatedly into slots 0-3, or 0-7 in eight mode.
// - Multichannel four mode takes a group of four by the top two field bits into slots 0-3.
// - Multichannel eight mode takes inputs 0-7 or reserved plus references by the top bit.
// - Each slot reads as right unsigned, left signed or left unsigned by address alone.
// - Every control write with byte lane 0 enabled starts a new sequence, aborting one in flight and clearing its flags.
// - A sequence is four conversions, or eight when the eight-conversion bit is set.
// - Scan clear runs one sequence, scan set repeats sequences without end.
// - A slot complete flag sets when its conversion ends and holds until its slot is read.
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_regs.svh"

module adc_channel_sequence_select #(
  parameter int RES_W = 10
) (
  // Clock, reset, enable
  input  wire logic                  I_CLK,
  input  wire logic                  I_RST,
  input  wire logic                  I_CE,
  // Wishbone slave
  input  wire logic                  I_WB_CYC,
  input  wire logic                  I_WB_STB,
  input  wire logic                  I_WB_WE,
  input  wire logic [7:0]            I_WB_ADR,
  input  wire logic [3:0]            I_WB_SEL,
  input  wire logic [31:0]           I_WB_DAT,
  output logic      [31:0]           O_WB_DAT,
  output logic                       O_WB_ACK,
  // Converter core
  output logic                       O_CONV_START,
  output adc_seq_pkg::chan_t         O_CONV_CHANNEL,
  input  wire logic                  I_CONV_DONE,
  input  wire logic [RES_W-1:0]      I_CONV_DATA,
  input  wire logic                  I_RES10,
  // Interrupt
  output logic                       O_IRQ
);
  import adc_seq_pkg::*;

  // Source for a slot; reserved codes are passed on unchanged to the core
  function automatic chan_t pick_channel(input slot_t s, input logic multichannel_select,
                                         input logic eight, input chan_t f);
    if (!multichannel_select) begin
      pick_channel = f;
    end else if (!eight) begin
      pick_channel = {f[3:2], s[1:0]};
    end else begin
      pick_channel = {f[3], s};
    end
  endfunction

  // Left-unsigned picture of a stored result
  function automatic logic [15:0] left_view(input logic [RES_W-1:0] r, input logic r10);
    left_view = r10 ? {r, 6'h00} : {r[7:0], 8'h00};
  endfunction

  seq_state_e        state, next_state;
  logic [6:0]        ctrl, next_ctrl;
  slot_t             cnt, next_cnt;
  logic [7:0]        done_flags, next_done_flags;
  logic              seq_flag, next_seq_flag;
  logic [RES_W-1:0]  slot_data [8];
  logic [RES_W-1:0]  next_slot_data [8];
  logic [7:0]        slot_r10, next_slot_r10;
  logic [1:0]        irq_stat, next_irq_stat;
  logic [1:0]        irq_mask, next_irq_mask;
  logic              ack, next_ack;
  logic [31:0]       rdat, next_rdat;

  logic              req, wr, rd;
  logic              ctrl_wr;
  logic [7:0]        slot_rd;
  slot_t             last;
  logic [2:0]        rd_idx;

  // Bus request decode; effects happen on the acking edge only
  assign req     = I_CE && I_WB_CYC && I_WB_STB && !ack;
  assign wr      = req && I_WB_WE;
  assign rd      = req && !I_WB_WE;
  assign ctrl_wr = wr && (I_WB_ADR == `CTRL_OFS) && I_WB_SEL[0];
  assign rd_idx  = I_WB_ADR[4:2];
  assign last    = ctrl[`CTRL_EIGHT_BIT] ? 3'h7 : 3'h3;

  // Any read of a view clears that slot's flag, whatever the format
  always_comb begin
    slot_rd = 8'h00;
    if (rd && (I_WB_ADR >= `RIGHT_VIEW_OFS) && (I_WB_ADR < 8'hA0)) begin
      slot_rd[rd_idx] = 1'b1;
    end
  end

  // Sequencer next state
  always_comb begin
    next_state      = state;
    next_ctrl       = ctrl;
    next_cnt        = cnt;
    next_done_flags = done_flags & ~slot_rd;
    next_seq_flag   = seq_flag;
    next_slot_data  = slot_data;
    next_slot_r10   = slot_r10;
    next_irq_stat   = irq_stat;
    if (rd && I_WB_ADR == `IRQ_STAT_OFS) begin
      next_irq_stat = 2'h0;
    end
    if (ctrl_wr) begin
      // Abort and restart from slot 0
      next_ctrl       = I_WB_DAT[6:0];
      next_state      = ST_START;
      next_cnt        = 3'h0;
      next_done_flags = 8'h00;
      next_seq_flag   = 1'b0;
    end else begin
      case (state)
        ST_START: begin
          next_state = ST_WAIT;
        end
        ST_WAIT: begin
          if (I_CONV_DONE) begin
            next_slot_data[cnt]  = I_CONV_DATA;
            next_slot_r10[cnt]   = I_RES10;
            next_done_flags[cnt] = 1'b1;
            next_irq_stat[`IRQ_SLOT_BIT] = 1'b1;
            if (cnt == last) begin
              next_seq_flag = 1'b1;
              next_irq_stat[`IRQ_SEQ_BIT] = 1'b1;
              next_cnt      = 3'h0;
              next_state    = ctrl[`CTRL_SCAN_BIT] ? ST_START : ST_IDLE;
            end else begin
              next_cnt   = cnt + 3'h1;
              next_state = ST_START;
            end
          end
        end
        default: begin
          next_state = ST_IDLE;
        end
      endcase
    end
  end

  // Sequencer registers; enable low freezes everything
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      state      <= ST_IDLE;
      ctrl       <= `CTRL_RESET;
      cnt        <= 3'h0;
      done_flags <= 8'h00;
      seq_flag   <= 1'b0;
      slot_data  <= '{default: '0};
      slot_r10   <= 8'h00;
      irq_stat   <= 2'h0;
    end else if (I_CE) begin
      state      <= next_state;
      ctrl       <= next_ctrl;
      cnt        <= next_cnt;
      done_flags <= next_done_flags;
      seq_flag   <= next_seq_flag;
      slot_data  <= next_slot_data;
      slot_r10   <= next_slot_r10;
      irq_stat   <= next_irq_stat;
    end
  end

  // Converter drive; start is a one-cycle pulse per conversion
  assign O_CONV_START   = I_CE && (state == ST_START);
  assign O_CONV_CHANNEL = pick_channel(cnt, ctrl[`CTRL_MULTICHANNEL_SELECT_BIT],
                                       ctrl[`CTRL_EIGHT_BIT], ctrl[3:0]);
  assign O_IRQ          = |(irq_stat & irq_mask);

  // Bus next values; unmapped reads return zero but still ack
  always_comb begin
    logic [15:0] lv;
    lv            = left_view(slot_data[rd_idx], slot_r10[rd_idx]);
    next_ack      = req;
    next_irq_mask = irq_mask;
    next_rdat     = 32'h0000_0000;
    if (wr && I_WB_ADR == `IRQ_MASK_OFS && I_WB_SEL[0]) begin
      next_irq_mask = I_WB_DAT[1:0];
    end
    if (rd) begin
      if (I_WB_ADR == `CTRL_OFS) begin
        next_rdat = {25'h0, ctrl};
      end else if (I_WB_ADR == `STAT_OFS) begin
        next_rdat = {16'h0, seq_flag, 4'h0, cnt, done_flags};
      end else if (I_WB_ADR == `IRQ_STAT_OFS) begin
        next_rdat = {30'h0, irq_stat};
      end else if (I_WB_ADR == `IRQ_MASK_OFS) begin
        next_rdat = {30'h0, irq_mask};
      end else if (I_WB_ADR[7:5] == 3'h2) begin
        // Right view is the left picture shifted down, so 8-bit zero-extends
        next_rdat = slot_r10[rd_idx] ? {22'h0, lv[15:6]} : {24'h0, lv[15:8]};
      end else if (I_WB_ADR[7:5] == 3'h3) begin
        next_rdat = {16'h0, lv ^ 16'h8000};
      end else if (I_WB_ADR[7:5] == 3'h4) begin
        next_rdat = {16'h0, lv};
      end
    end
  end

  // Bus registers
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      ack      <= 1'b0;
      rdat     <= 32'h0000_0000;
      irq_mask <= 2'h0;
    end else if (I_CE) begin
      ack      <= next_ack;
      rdat     <= next_rdat;
      irq_mask <= next_irq_mask;
    end
  end

  assign O_WB_ACK = ack;
  assign O_WB_DAT = rdat;

  // Checks
  sequence conv_finish;
    state == ST_WAIT && I_CONV_DONE && I_CE;
  endsequence

  sequence restart;
    ctrl_wr ##1 (state == ST_START && cnt == 3'h0);
  endsequence

  write_restart_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    ctrl_wr |=> (state == ST_START && cnt == 3'h0 && done_flags == 8'h00 && !seq_flag))
    else $error("control write did not restart the sequence");

  restart_start_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    restart |-> O_CONV_START || !I_CE)
    else $error("restart did not issue a start");

  flag_set_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    conv_finish and !ctrl_wr |=> done_flags[$past(cnt)])
    else $error("slot flag not set on finish");

  flag_hold_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    (I_CE && done_flags[0] && !slot_rd[0] && !ctrl_wr) |=> done_flags[0])
    else $error("slot flag dropped without read");

  seq_len_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    conv_finish and (cnt == last) and !ctrl_wr |=> cnt == 3'h0 && seq_flag)
    else $error("sequence length wrong");

  four_limit_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    !ctrl[`CTRL_EIGHT_BIT] && state != ST_IDLE |-> cnt <= 3'h3)
    else $error("four mode passed slot 3");

  scan_stop_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    conv_finish and (cnt == last) and !ctrl_wr and !ctrl[`CTRL_SCAN_BIT]
      |=> state == ST_IDLE)
    else $error("single sequence did not stop");

  scan_go_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    conv_finish and (cnt == last) and !ctrl_wr and ctrl[`CTRL_SCAN_BIT]
      |=> state == ST_START)
    else $error("scan did not repeat");

  single_chan_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    !ctrl[`CTRL_MULTICHANNEL_SELECT_BIT] |-> O_CONV_CHANNEL == ctrl[3:0])
    else $error("single channel mode changed channel");

  group_chan_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    ctrl[`CTRL_MULTICHANNEL_SELECT_BIT] && !ctrl[`CTRL_EIGHT_BIT]
      |-> O_CONV_CHANNEL == {ctrl[3:2], cnt[1:0]})
    else $error("group of four wrong");

  eight_chan_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    ctrl[`CTRL_MULTICHANNEL_SELECT_BIT] && ctrl[`CTRL_EIGHT_BIT] |-> O_CONV_CHANNEL == {ctrl[3], cnt})
    else $error("eight channel order wrong");

  view_luns_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    rd && I_WB_ADR[7:5] == 3'h4 |=> O_WB_ACK && O_WB_DAT[5:0] == 6'h00)
    else $error("left view low bits not zero");

endmodule
`default_nettype wire

// ==== adc_seq_tb.sv ====
// Purpose: Self-checking bench for the channel sequencer
// Assumes: Bench plays the converter core, one done pulse per start
// Notes:   Inputs change at rising edges; a monitor logs every start pulse
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_regs.svh"

module testbench;
  import adc_seq_pkg::*;
  logic        clk, rst, cyc, stb, we, done, res10, ack, start, irq;
  logic [7:0]  adr;
  logic [31:0] wdat, rdat, q;
  logic [9:0]  cdat;
  chan_t       chan;
  int          err_total, total_checks;
  int          starts, served;
  chan_t       start_chan;

  // Enable and byte lanes tied on: freezing is not under test here
  adc_channel_sequence_select dut (
    .I_CLK(clk), .I_RST(rst), .I_CE(1'b1), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we),
    .I_WB_ADR(adr), .I_WB_SEL(4'hF), .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack),
    .O_CONV_START(start), .O_CONV_CHANNEL(chan), .I_CONV_DONE(done), .I_CONV_DATA(cdat),
    .I_RES10(res10), .O_IRQ(irq));

  // Free-running system clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Log every start with its channel; the first one lands inside the ack cycle
  always @(posedge clk) begin
    if (start === 1'b1) begin
      starts     <= starts + 1;
      start_chan <= chan;
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Classic cycle; the wait is bounded so a dead slave cannot hang us
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    chk("ack", 1, ack);
  endtask

  // Take the next logged start, check its channel, answer with one done
  task automatic conv(input chan_t ch, input logic [9:0] d);
    int n;
    n = 0;
    while (starts == served && n < 50) begin
      @(posedge clk);
      n++;
    end
    served++;
    chk("start", served, starts);
    chk("channel", {28'h0, ch}, {28'h0, start_chan});
    done  <= 1'b1;
    cdat  <= d;
    res10 <= (d[9:8] != 2'h0);
    @(posedge clk);
    done <= 1'b0;
  endtask

  task automatic t_reset;
    wb(0, `CTRL_OFS, 0);
    chk("ctrl", 0, q);
    wb(0, `STAT_OFS, 0);
    chk("status", 0, q);
    wb(0, `IRQ_MASK_OFS, 0);
    chk("mask", 0, q);
    wb(0, 8'hFC, 0);
    chk("unmapped", 0, q);
  endtask

  // One-shot single-channel runs, four then eight, with the sequence interrupt
  task automatic t_single;
    wb(1, `IRQ_MASK_OFS, 32'h2);
    wb(1, `CTRL_OFS, 32'h0C);
    for (int i = 0; i < 4; i++) conv(4'hC, 10'h100);
    repeat (6) begin
      @(negedge clk);
      chk("idle", 0, start);
    end
    wb(0, `STAT_OFS, 0);
    chk("status", 32'h800F, q & 32'h80FF);
    chk("irq", 1, irq);
    wb(0, `IRQ_STAT_OFS, 0);
    chk("irq_stat", 3, q);
    chk("irq", 0, irq);
    wb(1, `CTRL_OFS, 32'h17);
    for (int i = 0; i < 8; i++) conv(4'h7, 10'h100);
    wb(0, `STAT_OFS, 0);
    chk("status", 32'h80FF, q & 32'h80FF);
  endtask

  // Every group of four, then both halves of eight, low field bits set
  task automatic t_multi;
    for (int g = 0; g < 4; g++) begin
      wb(1, `CTRL_OFS, 32'h23 | (g << 2));
      for (int i = 0; i < 4; i++) conv(chan_t'(g * 4 + i), 10'h100);
    end
    for (int t = 0; t < 2; t++) begin
      wb(1, `CTRL_OFS, 32'h37 | (t << 3));
      for (int i = 0; i < 8; i++) conv(chan_t'(t * 8 + i), 10'h100);
    end
  endtask

  // Odd slots carry 8-bit results, even slots 10-bit ones
  task automatic t_views;
    logic [9:0]  d;
    logic [31:0] l;
    wb(1, `CTRL_OFS, 32'h10);
    for (int i = 0; i < 8; i++) conv(4'h0, 10'(i[0] ? 32'h0A0 + i : 32'h300 + i));
    for (int i = 0; i < 8; i++) begin
      d = 10'(i[0] ? 32'h0A0 + i : 32'h300 + i);
      l = i[0] ? {16'h0, d[7:0], 8'h0} : {16'h0, d, 6'h0};
      wb(0, `RIGHT_VIEW_OFS + 8'(4 * i), 0);
      chk("right", i[0] ? {24'h0, d[7:0]} : {22'h0, d}, q);
      wb(0, `LSIGN_VIEW_OFS + 8'(4 * i), 0);
      chk("lsigned", l ^ 32'h8000, q);
      wb(0, `LUNS_VIEW_OFS + 8'(4 * i), 0);
      chk("lunsigned", l, q);
      wb(0, `STAT_OFS, 0);
      chk("flags", (32'hFF << (i + 1)) & 32'hFF, q & 32'hFF);
    end
  endtask

  // Scan repeats; a control write mid-sequence aborts and clears flags
  task automatic t_abort;
    wb(1, `CTRL_OFS, 32'h45);
    for (int i = 0; i < 5; i++) conv(4'h5, 10'h100);
    wb(0, `STAT_OFS, 0);
    chk("status", 32'h800F, q & 32'h80FF);
    // Scan has already restarted; that pending start is never answered
    served = starts;
    wb(1, `CTRL_OFS, 32'h01);
    wb(0, `STAT_OFS, 0);
    chk("abort", 0, q & 32'h80FF);
    for (int i = 0; i < 4; i++) conv(4'h1, 10'h100);
  endtask

  task automatic results;
    if (err_total == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Watchdog: the whole run needs a few hundred cycles
  initial begin
    #200000;
    err_total++;
    results;
  end

  // Main sequence
  initial begin
    {rst, cyc, stb, we, done, res10, adr, wdat, cdat} = '0;
    rst          = 1'b1;
    err_total    = 0;
    total_checks = 0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_single;
    t_multi;
    t_views;
    t_abort;
    results;
  end
endmodule
`default_nettype wire
